// ### core/rsc_pkg.sv
package rsc_pkg;
    localparam int RSC_MAX_CH = 32;
    localparam int RSC_CW = 5;
    localparam int RSC_NUM_CH = 20;
    localparam logic [7:0] RSC_A_KEY = 8'h00;
    localparam logic [7:0] RSC_A_CHAN = 8'h04;
    localparam logic [7:0] RSC_A_RELAY = 8'h08;
    localparam logic [7:0] RSC_A_DIO = 8'h0C;
    localparam logic [7:0] RSC_A_TIME = 8'h10;
    localparam logic [7:0] RSC_A_DATE = 8'h14;
    localparam logic [7:0] RSC_A_SETUP = 8'h18;
    localparam logic [7:0] RSC_A_INTV = 8'h1C;
    localparam int RSC_KEY_LSB = 0;
    localparam int RSC_DIG_LSB = 8;
    localparam int RSC_CH_FIRST_LSB = 8;
    localparam int RSC_CH_LAST_LSB = 16;
    localparam int RSC_CH_FAULT_BIT = 24;
    localparam int RSC_CH_MODE_LSB = 25;
    localparam int RSC_CH_RUN_BIT = 28;
    localparam int RSC_CH_SINGLE_BIT = 29;
    localparam int RSC_CH_CONT_BIT = 30;
    localparam int RSC_DIO_IN_LSB = 3;
    localparam logic [2:0] RSC_DOUT_RST = 3'h0;
    localparam logic [23:0] RSC_ALARM_RST = 24'h000000;
    localparam logic [19:0] RSC_INTV_DEF = 20'h0000A;
    localparam logic [4:0] RSC_ADDR_DEF = 5'h11;
    localparam logic [1:0] RSC_POLES_DEF = 2'h2;
    localparam logic [7:0] RSC_SETTLE_DEF = 8'h00;
    localparam logic [7:0] RSC_P_LOOP = 8'h90;
    localparam logic [7:0] RSC_P_91 = 8'h91;
    localparam logic [7:0] RSC_P_92 = 8'h92;
    localparam logic [7:0] RSC_P_RESTORE = 8'h99;
    localparam logic [7:0] RSC_GL_OPEN = 8'h30;
    localparam logic [7:0] RSC_GL_CLOSED = 8'h43;
    localparam logic [7:0] RSC_GL_FIRST = 8'h46;
    localparam logic [7:0] RSC_GL_LAST = 8'h4C;
    localparam logic [7:0] RSC_GL_BOTH = 8'h42;
    localparam logic [7:0] RSC_GL_BLANK = 8'h20;

    typedef enum logic [4:0] {
        RSC_K_CHAN = 5'h00,
        RSC_K_TIME = 5'h01,
        RSC_K_DATE = 5'h02,
        RSC_K_PROG = 5'h03,
        RSC_K_SINGLE = 5'h04,
        RSC_K_CONT = 5'h05,
        RSC_K_INTV = 5'h06,
        RSC_K_RESET = 5'h07,
        RSC_K_CLOSE = 5'h08,
        RSC_K_OPEN = 5'h09,
        RSC_K_FIRST = 5'h0A,
        RSC_K_LAST = 5'h0B,
        RSC_K_SS = 5'h0C,
        RSC_K_DIGIT = 5'h0D,
        RSC_K_ENTER = 5'h0E
    } rsc_key_t;

    typedef enum logic [2:0] {
        RSC_M_CHAN = 3'h0,
        RSC_M_TIME = 3'h1,
        RSC_M_DATE = 3'h2,
        RSC_M_PROG = 3'h3,
        RSC_M_SINGLE = 3'h4,
        RSC_M_CONT = 3'h5,
        RSC_M_INTV = 3'h6
    } rsc_mode_t;

    typedef struct packed {
        logic [3:0] tens;
        logic [3:0] ones;
        logic [7:0] tag;
        logic [7:0] stat;
    } rsc_disp_t;

    typedef struct packed {
        logic [7:0] settle;
        logic [4:0] addr;
        logic [1:0] poles;
        logic fmt;
    } rsc_setup_t;

    typedef struct packed {
        rsc_mode_t mode;
        logic chan;
        logic [RSC_CW-1:0] sel;
        logic [RSC_MAX_CH-1:0] relay;
        logic [RSC_MAX_CH-1:0] saved;
        logic single;
        logic cont;
        logic run;
        logic [2:0] dout;
        logic [23:0] alarm;
        logic [7:0] prog;
        logic [1:0] pdig;
        logic fault;
        logic [2:0] d1;
        logic [2:0] d2;
        logic [2:0] d3;
        logic [2:0] din_f;
        logic [2:0] lsync;
        logic [RSC_CW-1:0] first;
        logic [RSC_CW-1:0] last;
        logic [23:0] time_v;
        logic [23:0] date_v;
        logic [19:0] intv;
        rsc_setup_t setup;
        logic [31:0] rd_data;
        rsc_disp_t disp;
    } rsc_state_t;
endpackage

// ### core/rsc_core.sv
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module rsc_core #(
    parameter int NUM_CH = rsc_pkg::RSC_NUM_CH
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic bat_rst_b,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [2:0] din,
    input wire logic loop_fault,
    output logic [31:0] rd_data,
    output rsc_pkg::rsc_disp_t disp,
    output logic [NUM_CH-1:0] relay_closed,
    output logic [2:0] dout,
    output logic chan_led,
    output logic run_led,
    output logic fault_msg
);
    localparam logic [rsc_pkg::RSC_CW-1:0] LAST_IDX =
        rsc_pkg::RSC_CW'(NUM_CH - 1);

    rsc_pkg::rsc_state_t st;
    rsc_pkg::rsc_state_t next_st;
    rsc_pkg::rsc_state_t pwr_st;
    rsc_pkg::rsc_state_t bat_st;
    logic key_go;
    rsc_pkg::rsc_key_t key;
    logic [3:0] digit;
    logic [7:0] prog_new;

    function automatic rsc_pkg::rsc_disp_t show(rsc_pkg::rsc_state_t s);
        rsc_pkg::rsc_disp_t d;
        logic [5:0] n;
        n = {1'b0, s.sel} + 6'h01;
        d.tens = 4'(n / 6'h0A);
        d.ones = 4'(n % 6'h0A);
        if (s.first == s.sel && s.last == s.sel)
            d.tag = rsc_pkg::RSC_GL_BOTH;
        else if (s.first == s.sel)
            d.tag = rsc_pkg::RSC_GL_FIRST;
        else if (s.last == s.sel)
            d.tag = rsc_pkg::RSC_GL_LAST;
        else
            d.tag = rsc_pkg::RSC_GL_BLANK;
        d.stat = s.relay[s.sel] ? rsc_pkg::RSC_GL_CLOSED
                                : rsc_pkg::RSC_GL_OPEN;
        return d;
    endfunction

    // Factory values, shared by battery loss and the restore program
    function automatic rsc_pkg::rsc_state_t restore(rsc_pkg::rsc_state_t s);
        rsc_pkg::rsc_state_t r;
        r = s;
        r.first = '0;
        r.last = LAST_IDX;
        r.intv = rsc_pkg::RSC_INTV_DEF;
        r.setup.settle = rsc_pkg::RSC_SETTLE_DEF;
        r.setup.addr = rsc_pkg::RSC_ADDR_DEF;
        r.setup.poles = rsc_pkg::RSC_POLES_DEF;
        r.setup.fmt = 1'b0;
        r.disp = show(r);
        return r;
    endfunction

    assign key_go = wr_en && addr == rsc_pkg::RSC_A_KEY;
    assign key = rsc_pkg::rsc_key_t'(wr_data[rsc_pkg::RSC_KEY_LSB +: 5]);
    assign digit = wr_data[rsc_pkg::RSC_DIG_LSB +: 4];
    assign prog_new = {st.prog[3:0], digit};

    // Volatile state only; battery-held fields pass through untouched
    always_comb
    begin
        pwr_st = st;
        pwr_st.mode = rsc_pkg::RSC_M_CHAN;
        pwr_st.sel = '0;
        pwr_st.relay = '0;
        pwr_st.single = 1'b0;
        pwr_st.cont = 1'b0;
        pwr_st.run = 1'b0;
        pwr_st.dout = rsc_pkg::RSC_DOUT_RST;
        pwr_st.saved = '0;
        pwr_st.alarm = rsc_pkg::RSC_ALARM_RST;
        pwr_st.prog = '0;
        pwr_st.pdig = '0;
        pwr_st.fault = 1'b0;
        pwr_st.chan = 1'b1;
        pwr_st.lsync = '0;
        pwr_st.rd_data = '0;
        pwr_st.disp = show(pwr_st);
        // Digital input stages kept on rst_b; battery loss clears them to zero
        bat_st = pwr_st;
        bat_st.d1 = '0;
        bat_st.d2 = '0;
        bat_st.d3 = '0;
        bat_st.din_f = '0;
        bat_st.time_v = '0;
        bat_st.date_v = '0;
        bat_st = restore(bat_st);
    end

    always_comb
    begin
        next_st = st;
        next_st.rd_data = '0;
        next_st.d1 = din;
        next_st.d2 = st.d1;
        next_st.d3 = st.d2;
        if (st.d2 == st.d3)
            next_st.din_f = st.d3;
        next_st.lsync = {st.lsync[1:0], loop_fault};
        if (key_go)
        begin
            unique case (key)
                rsc_pkg::RSC_K_CHAN:
                    if (st.mode == rsc_pkg::RSC_M_CHAN)
                        next_st.sel = (st.sel == LAST_IDX) ? '0
                                      : st.sel + 1'b1;
                    else
                        next_st.mode = rsc_pkg::RSC_M_CHAN;
                rsc_pkg::RSC_K_TIME:
                    next_st.mode = rsc_pkg::RSC_M_TIME;
                rsc_pkg::RSC_K_DATE:
                    next_st.mode = rsc_pkg::RSC_M_DATE;
                rsc_pkg::RSC_K_INTV:
                    next_st.mode = rsc_pkg::RSC_M_INTV;
                rsc_pkg::RSC_K_PROG:
                begin
                    next_st.mode = rsc_pkg::RSC_M_PROG;
                    next_st.prog = '0;
                    next_st.pdig = '0;
                end
                rsc_pkg::RSC_K_SINGLE:
                begin
                    next_st.mode = rsc_pkg::RSC_M_SINGLE;
                    next_st.single = 1'b1;
                    next_st.cont = 1'b0;
                end
                rsc_pkg::RSC_K_CONT:
                begin
                    next_st.mode = rsc_pkg::RSC_M_CONT;
                    next_st.cont = 1'b1;
                    next_st.single = 1'b0;
                end
                rsc_pkg::RSC_K_SS:
                    next_st.run = !st.run;
                rsc_pkg::RSC_K_RESET:
                    if (st.mode == rsc_pkg::RSC_M_PROG)
                    begin
                        if (st.prog != rsc_pkg::RSC_P_LOOP
                            && st.prog != rsc_pkg::RSC_P_91
                            && st.prog != rsc_pkg::RSC_P_92
                            && st.prog != rsc_pkg::RSC_P_RESTORE)
                            next_st.mode = rsc_pkg::RSC_M_CHAN;
                    end
                    else if (st.mode == rsc_pkg::RSC_M_CHAN
                             || st.mode == rsc_pkg::RSC_M_SINGLE
                             || st.mode == rsc_pkg::RSC_M_CONT)
                    begin
                        // Time, date and interval modes ignore reset
                        next_st.relay = '0;
                        next_st.sel = st.first;
                        next_st.run = 1'b0;
                    end
                rsc_pkg::RSC_K_CLOSE:
                    if (st.mode == rsc_pkg::RSC_M_CHAN)
                        next_st.relay[st.sel] = 1'b1;
                rsc_pkg::RSC_K_OPEN:
                    if (st.mode == rsc_pkg::RSC_M_CHAN)
                        next_st.relay[st.sel] = 1'b0;
                rsc_pkg::RSC_K_FIRST:
                    // One index register, so the old mark goes at once
                    if (st.mode == rsc_pkg::RSC_M_CHAN)
                        next_st.first = st.sel;
                rsc_pkg::RSC_K_LAST:
                    if (st.mode == rsc_pkg::RSC_M_CHAN)
                        next_st.last = st.sel;
                rsc_pkg::RSC_K_DIGIT:
                    if (st.mode == rsc_pkg::RSC_M_PROG && st.pdig != 2'h2)
                    begin
                        next_st.prog = prog_new;
                        next_st.pdig = st.pdig + 2'h1;
                        // Loop recovery runs without an enter key
                        if (st.pdig == 2'h1 && prog_new == rsc_pkg::RSC_P_LOOP)
                        begin
                            next_st.fault = 1'b0;
                            next_st.mode = rsc_pkg::RSC_M_CHAN;
                        end
                    end
                rsc_pkg::RSC_K_ENTER:
                    if (st.mode == rsc_pkg::RSC_M_PROG
                        && st.prog == rsc_pkg::RSC_P_RESTORE)
                    begin
                        next_st = restore(next_st);
                        next_st.mode = rsc_pkg::RSC_M_CHAN;
                    end
                default:
                begin
                end
            endcase
        end
        // Fault seen on the pin wins over a clear in the same cycle
        if (st.lsync[1] && st.lsync[2])
            next_st.fault = 1'b1;
        if (wr_en)
        begin
            unique case (addr)
                rsc_pkg::RSC_A_DIO:
                    next_st.dout = wr_data[2:0];
                rsc_pkg::RSC_A_TIME:
                    next_st.time_v = wr_data[23:0];
                rsc_pkg::RSC_A_DATE:
                    next_st.date_v = wr_data[23:0];
                rsc_pkg::RSC_A_SETUP:
                    next_st.setup = wr_data[15:0];
                rsc_pkg::RSC_A_INTV:
                    next_st.intv = wr_data[19:0];
                default:
                begin
                end
            endcase
        end
        if (rd_en)
        begin
            unique case (addr)
                rsc_pkg::RSC_A_KEY:
                    next_st.rd_data = '0;
                rsc_pkg::RSC_A_CHAN:
                begin
                    next_st.rd_data[rsc_pkg::RSC_CW-1:0] = st.sel;
                    next_st.rd_data[rsc_pkg::RSC_CH_FIRST_LSB +:
                                    rsc_pkg::RSC_CW] = st.first;
                    next_st.rd_data[rsc_pkg::RSC_CH_LAST_LSB +:
                                    rsc_pkg::RSC_CW] = st.last;
                    next_st.rd_data[rsc_pkg::RSC_CH_FAULT_BIT] = st.fault;
                    next_st.rd_data[rsc_pkg::RSC_CH_MODE_LSB +: 3] = st.mode;
                    next_st.rd_data[rsc_pkg::RSC_CH_RUN_BIT] = st.run;
                    next_st.rd_data[rsc_pkg::RSC_CH_SINGLE_BIT] = st.single;
                    next_st.rd_data[rsc_pkg::RSC_CH_CONT_BIT] = st.cont;
                end
                rsc_pkg::RSC_A_RELAY:
                    next_st.rd_data[NUM_CH-1:0] = st.relay[NUM_CH-1:0];
                rsc_pkg::RSC_A_DIO:
                begin
                    next_st.rd_data[2:0] = st.dout;
                    next_st.rd_data[rsc_pkg::RSC_DIO_IN_LSB +: 3] = st.din_f;
                end
                rsc_pkg::RSC_A_TIME:
                    next_st.rd_data[23:0] = st.time_v;
                rsc_pkg::RSC_A_DATE:
                    next_st.rd_data[23:0] = st.date_v;
                rsc_pkg::RSC_A_SETUP:
                    next_st.rd_data[15:0] = st.setup;
                rsc_pkg::RSC_A_INTV:
                    next_st.rd_data[19:0] = st.intv;
                default:
                    next_st.rd_data = '0;
            endcase
        end
        next_st.chan = next_st.mode == rsc_pkg::RSC_M_CHAN;
        next_st.disp = show(next_st);
    end

    // Battery-held fields survive rst_b; only bat_rst_b clears them
    always_ff @(posedge clock)
    begin
        if (!bat_rst_b)
            st <= bat_st;
        else if (!rst_b)
            st <= pwr_st;
        else
            st <= next_st;
    end

    assign rd_data = st.rd_data;
    assign disp = st.disp;
    assign relay_closed = st.relay[NUM_CH-1:0];
    assign dout = st.dout;
    assign chan_led = st.chan;
    assign run_led = st.run;
    assign fault_msg = st.fault;

    property p_pwr_chan;
        @(posedge clock) disable iff (!bat_rst_b)
        $rose(rst_b) |-> st.mode == rsc_pkg::RSC_M_CHAN && st.sel == '0
            && st.relay == '0 && disp.ones == 4'h1 && disp.tens == 4'h0;
    endproperty
    a_pwr_chan: assert property (p_pwr_chan)
        else $error("power-up not in channel 1 with relays open");

    property p_pwr_scan;
        @(posedge clock) disable iff (!bat_rst_b)
        $rose(rst_b) |-> !st.single && !st.cont && !run_led
            && dout == 3'h0 && st.saved == '0 && st.alarm == 24'h000000;
    endproperty
    a_pwr_scan: assert property (p_pwr_scan)
        else $error("power-up scan, output or alarm defaults wrong");

    property p_keep_marks;
        @(posedge clock) disable iff (!bat_rst_b)
        !rst_b |=> st.first == $past(st.first) && st.last == $past(st.last)
            && st.intv == $past(st.intv) && st.setup == $past(st.setup);
    endproperty
    a_keep_marks: assert property (p_keep_marks)
        else $error("battery-held value lost on power-up");

    property p_chan_step;
        @(posedge clock) disable iff (!rst_b)
        key_go && key == rsc_pkg::RSC_K_CHAN
            && st.mode == rsc_pkg::RSC_M_CHAN && st.sel != LAST_IDX
        |=> st.sel == $past(st.sel) + 1'b1;
    endproperty
    a_chan_step: assert property (p_chan_step)
        else $error("channel key did not advance by one");

    property p_leave;
        @(posedge clock) disable iff (!rst_b)
        key_go && (key == rsc_pkg::RSC_K_TIME || key == rsc_pkg::RSC_K_PROG
            || key == rsc_pkg::RSC_K_SINGLE || key == rsc_pkg::RSC_K_INTV)
        |=> !chan_led;
    endproperty
    a_leave: assert property (p_leave)
        else $error("mode key left channel mode lit");

    property p_close;
        @(posedge clock) disable iff (!rst_b)
        key_go && key == rsc_pkg::RSC_K_CLOSE && chan_led
        |=> st.relay[$past(st.sel)] && disp.stat == rsc_pkg::RSC_GL_CLOSED
            ##1 st.relay[$past(st.sel, 2)];
    endproperty
    a_close: assert property (p_close)
        else $error("close key did not close shown channel");

    property p_open;
        @(posedge clock) disable iff (!rst_b)
        key_go && key == rsc_pkg::RSC_K_OPEN && chan_led
        |=> !st.relay[$past(st.sel)] && disp.stat == rsc_pkg::RSC_GL_OPEN;
    endproperty
    a_open: assert property (p_open)
        else $error("open key did not open shown channel");

    property p_first;
        @(posedge clock) disable iff (!rst_b)
        key_go && key == rsc_pkg::RSC_K_FIRST && chan_led
        |=> st.first == $past(st.sel) && disp.tag != rsc_pkg::RSC_GL_BLANK
            && disp.tag != rsc_pkg::RSC_GL_LAST;
    endproperty
    a_first: assert property (p_first)
        else $error("first key did not mark shown channel");

    property p_last;
        @(posedge clock) disable iff (!rst_b)
        key_go && key == rsc_pkg::RSC_K_LAST && chan_led
        |=> st.last == $past(st.sel) && disp.tag != rsc_pkg::RSC_GL_BLANK
            && disp.tag != rsc_pkg::RSC_GL_FIRST;
    endproperty
    a_last: assert property (p_last)
        else $error("last key did not mark shown channel");

    property p_din_keep;
        @(posedge clock) disable iff (!bat_rst_b)
        !rst_b |=> st.din_f == $past(st.din_f) && st.d3 == $past(st.d3);
    endproperty
    a_din_keep: assert property (p_din_keep)
        else $error("digital input state changed on power-up");

    property p_loop;
        @(posedge clock) disable iff (!rst_b)
        key_go && key == rsc_pkg::RSC_K_DIGIT && st.mode == rsc_pkg::RSC_M_PROG
            && st.pdig == 2'h1 && prog_new == rsc_pkg::RSC_P_LOOP
            && !loop_fault ##1 !loop_fault [*3]
        |-> !fault_msg && chan_led;
    endproperty
    a_loop: assert property (p_loop)
        else $error("loop recovery program left fault shown");
endmodule

// ### sim/rsc_operator.sv
`timescale 1ns/100ps
module rsc_operator (
    input wire logic clock,
    output logic [7:0] addr,
    output logic [31:0] wr_data,
    output logic wr_en,
    output logic rd_en,
    input wire logic [31:0] rd_data,
    output logic [2:0] din,
    output logic loop_fault
);
    initial
    begin
        addr = 8'h00;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        din = 3'h0;
        loop_fault = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    // Data taken just after the edge that takes the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic press(input rsc_pkg::rsc_key_t k, input logic [3:0] g);
        wr(8'h00, {20'h0, g, 3'h0, k});
    endtask
    // Program key, two digits, then enter if asked
    task automatic prog(input logic [7:0] p, input logic ent);
        press(rsc_pkg::RSC_K_PROG, 4'h0);
        press(rsc_pkg::RSC_K_DIGIT, p[7:4]);
        press(rsc_pkg::RSC_K_DIGIT, p[3:0]);
        if (ent)
            press(rsc_pkg::RSC_K_ENTER, 4'h0);
    endtask
    // Pins are asynchronous; the synchroniser takes any phase
    task automatic pins(input logic [2:0] d, input logic f);
        @(posedge clock);
        din <= d;
        loop_fault <= f;
    endtask
endmodule

// ### sim/relay_scan_channel_control_tb_top.sv
`timescale 1ns/100ps
module relay_scan_channel_control_tb_top;
    localparam int NCH = rsc_pkg::RSC_NUM_CH;
    logic clock, rst_b, bat_rst_b, wr_en, rd_en, loop_fault;
    logic chan_led, run_led, fault_msg;
    logic [7:0] addr;
    logic [31:0] wr_data, rd_data, d, v;
    logic [2:0] din, dout;
    logic [NCH-1:0] relay_closed, mrel;
    rsc_pkg::rsc_disp_t disp;
    logic [31:0] seed = 32'h8DEB;
    int num_errors = 0;
    int checks = 0;
    int sel, first, last, n;
    rsc_pkg::rsc_key_t mk[6] = '{rsc_pkg::RSC_K_TIME, rsc_pkg::RSC_K_DATE,
        rsc_pkg::RSC_K_PROG, rsc_pkg::RSC_K_SINGLE, rsc_pkg::RSC_K_CONT,
        rsc_pkg::RSC_K_INTV};
    rsc_core #(.NUM_CH(NCH)) i_rsc_core (.clock(clock), .rst_b(rst_b),
        .bat_rst_b(bat_rst_b), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .din(din), .loop_fault(loop_fault),
        .rd_data(rd_data), .disp(disp), .relay_closed(relay_closed),
        .dout(dout), .chan_led(chan_led), .run_led(run_led),
        .fault_msg(fault_msg));
    rsc_operator i_rsc_operator (.clock(clock), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .din(din), .loop_fault(loop_fault));
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic key(rsc_pkg::rsc_key_t k);
        i_rsc_operator.press(k, 4'h0);
    endtask
    // Registered display changes on the same edge as the state
    task automatic look(logic cm);
        logic [7:0] tg;
        repeat (2) @(posedge clock);
        #1 tg = 8'h20;
        if (sel == first && sel == last)
            tg = 8'h42;
        else if (sel == first)
            tg = 8'h46;
        else if (sel == last)
            tg = 8'h4C;
        chk("disp", 32'(disp), {4'(sel / 10), 4'(sel % 10), tg,
            mrel[sel-1] ? 8'h43 : 8'h30});
        chk("relays", 32'(relay_closed), 32'(mrel));
        chk("chan_led", 32'(chan_led), 32'(cm));
    endtask
    task automatic pwr();
        @(posedge clock);
        rst_b <= 1'b0;
        @(posedge clock);
        rst_b <= 1'b1;
        sel = 1;
        mrel = '0;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        num_errors++;
        stop_test();
    end
    initial
    begin
        rst_b = 1'b0;
        bat_rst_b = 1'b0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        bat_rst_b <= 1'b1;
        sel = 1;
        first = 1;
        last = NCH;
        mrel = '0;
        look(1'b1);
        chk("dout", 32'(dout), 32'h0);
        chk("run", 32'(run_led), 32'h0);
        $display("test power_up done");
        repeat (12)
        begin
            n = rnd() % 7 + 1;
            repeat (n)
            begin
                key(rsc_pkg::RSC_K_CHAN);
                sel = sel % NCH + 1;
            end
            v = rnd();
            mrel[sel-1] = v[0];
            repeat (2) key(v[0] ? rsc_pkg::RSC_K_CLOSE : rsc_pkg::RSC_K_OPEN);
            look(1'b1);
        end
        $display("test relays done");
        key(rsc_pkg::RSC_K_FIRST);
        first = sel;
        look(1'b1);
        key(rsc_pkg::RSC_K_CHAN);
        sel = sel % NCH + 1;
        repeat (2) key(rsc_pkg::RSC_K_LAST);
        last = sel;
        look(1'b1);
        i_rsc_operator.rd(8'h04, d);
        chk("first", 32'(d[12:8]), 32'(first - 1));
        chk("last", 32'(d[20:16]), 32'(last - 1));
        $display("test marks done");
        v = rnd();
        i_rsc_operator.wr(8'h10, {8'h0, v[23:0]});
        i_rsc_operator.wr(8'h18, {16'h0, v[31:16]});
        i_rsc_operator.wr(8'h0C, {29'h0, v[2:0]});
        i_rsc_operator.pins(v[5:3], 1'b0);
        // Let the input synchroniser settle before power drops
        repeat (5) @(posedge clock);
        #1 chk("dout", 32'(dout), 32'(v[2:0]));
        pwr();
        i_rsc_operator.rd(8'h0C, d);
        chk("din", 32'(d[5:3]), 32'(v[5:3]));
        look(1'b1);
        chk("dout", 32'(dout), 32'h0);
        i_rsc_operator.rd(8'h10, d);
        chk("time", d, {8'h0, v[23:0]});
        i_rsc_operator.rd(8'h18, d);
        chk("setup", d, {16'h0, v[31:16]});
        $display("test power_loss done");
        foreach (mk[i])
        begin
            key(mk[i]);
            look(1'b0);
            i_rsc_operator.rd(8'h04, d);
            chk("mode", 32'(d[27:25]), 32'(i + 1));
            key(rsc_pkg::RSC_K_CHAN);
        end
        key(rsc_pkg::RSC_K_PROG);
        key(rsc_pkg::RSC_K_RESET);
        look(1'b1);
        i_rsc_operator.prog(8'h91, 1'b0);
        key(rsc_pkg::RSC_K_RESET);
        look(1'b0);
        key(rsc_pkg::RSC_K_CHAN);
        $display("test modes done");
        key(rsc_pkg::RSC_K_CLOSE);
        mrel[sel-1] = 1'b1;
        key(rsc_pkg::RSC_K_SINGLE);
        key(rsc_pkg::RSC_K_SS);
        key(rsc_pkg::RSC_K_CONT);
        repeat (2) @(posedge clock);
        #1 chk("run", 32'(run_led), 32'h1);
        key(rsc_pkg::RSC_K_RESET);
        sel = first;
        mrel = '0;
        look(1'b0);
        chk("run", 32'(run_led), 32'h0);
        key(rsc_pkg::RSC_K_SS);
        pwr();
        look(1'b1);
        chk("run", 32'(run_led), 32'h0);
        i_rsc_operator.rd(8'h04, d);
        chk("scan", 32'(d[30:28]), 32'h0);
        $display("test scan_flags done");
        i_rsc_operator.pins(3'h0, 1'b1);
        repeat (6) @(posedge clock);
        #1 chk("fault", 32'(fault_msg), 32'h1);
        i_rsc_operator.pins(3'h0, 1'b0);
        repeat (6) @(posedge clock);
        i_rsc_operator.prog(8'h90, 1'b0);
        look(1'b1);
        chk("fault", 32'(fault_msg), 32'h0);
        repeat (3)
        begin
            key(rsc_pkg::RSC_K_CHAN);
            sel = sel % NCH + 1;
        end
        key(rsc_pkg::RSC_K_FIRST);
        first = sel;
        look(1'b1);
        i_rsc_operator.prog(8'h99, 1'b1);
        first = 1;
        last = NCH;
        look(1'b1);
        i_rsc_operator.rd(8'h04, d);
        chk("range", 32'(d[20:8]), {19'h0, 5'(NCH - 1), 8'h00});
        i_rsc_operator.rd(8'hF0, d);
        chk("unmapped", d, 32'h0);
        $display("test programs done");
        stop_test();
    end
endmodule
